// *** rtl/timer_event_irq_dma_control.sv ***
// Event, interrupt and DMA request control slice of the timer.
// What this block does
// - Sync bit picks trigger input as start
// - DMA request only when its enable set
// - Interrupt enables gate each source's interrupt
// - System break flag clearable only when inactive
// - Capture on channels 0 to 3 with flag set raises over-capture
// - Second break input sets its flag
// - First break input sets its flag
// - Commutation event sets sticky commutation flag
// - Capture or compare sets channel flag
// - Update event sets sticky update flag
// - Second break generation: outputs off, flag
// - First break generation: outputs off, flag
// - Trigger generation sets trigger flag
// - Commutation generation loads shadowed channel controls
// - Channel generation sets flag, captures in input
// - Update generation clears or reloads counter
// - Four-bit compare control, top bit apart
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module timer_event_irq_dma_control
  import timer_evt_pkg::*;
#(
  parameter int NUM_CC = 4
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // AHB-Lite register bus.
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Events from the rest of the timer.
  input  wire logic        updEvt,
  input  wire logic [4:0]  ccEvt,
  input  wire logic [2:0]  chanInputModeHi,
  input  wire logic        trigEvt,
  input  wire logic        commutEvt,
  input  wire logic        triggerIn,
  input  wire logic        breakInputA,
  input  wire logic        breakInputB,
  input  wire logic        sysBreakActive,
  input  wire logic        countDown,
  input  wire logic [9:0]  chanEnShadow,
  // Requests and controls to the rest of the timer.
  output logic [7:0]       irqLines,
  output logic [6:0]       dmaReq,
  output logic             syncStartPulse,
  output logic             counterClear,
  output logic             counterReload,
  output logic             prescalerClear,
  output logic [4:0]       ccCaptureReq,
  output logic             mainOutEnable,
  output logic [9:0]       chanEnActive,
  output logic [3:0]       chan0CmpMode,
  output logic [3:0]       chan1CmpMode
);

  // Compare control of one channel, its top bit apart from the low three.
  // Both channels use it, so the split is decoded once.
  function automatic logic [3:0] cmpField(input logic [31:0] r,
                                          input logic        ch);
    cmpField = ch ? {r[CH1_CMP_HI], r[CH1_CMP_LO +: 3]}
                  : {r[CH0_CMP_HI], r[CH0_CMP_LO +: 3]};
  endfunction

  reg_access_if regBus ();

  // Software-visible register contents.
  logic [31:0] slaveCfg_q;
  logic [31:0] dmaIrqEn_q;
  logic [31:0] chanCtrlA_q;
  logic [31:0] outCtrl_q;
  logic [8:0]  softGen_q;

  // Flag state and its set and clear terms.
  logic [16:0] flags;
  logic [16:0] flagSet;
  logic [16:0] flagClrOk;

  // Event sources merged from pins and generation bits.
  logic [4:0]  ccAll;
  logic [4:0]  inMode;
  logic        commutAny;
  logic        brkAAny;
  logic        brkBAny;
  logic        trigPrev_q;

  // Write strobes decoded from the register bus.
  logic        wrSlave;
  logic        wrDmaIrq;
  logic        wrFlags;
  logic        wrSoft;
  logic        wrChan;
  logic        wrOut;

  // Bus slave.
  // One wait state per transfer keeps read data registered.
  ahb_reg_slave u_slave (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .regs      (regBus.slave)
  );

  // Address decode of write strobes.
  // Writes to unmapped offsets match no strobe and vanish.
  assign wrSlave  = regBus.wrEn & (regBus.addr == OFF_SLAVE_CFG);
  assign wrDmaIrq = regBus.wrEn & (regBus.addr == OFF_DMA_IRQ_EN);
  assign wrFlags  = regBus.wrEn & (regBus.addr == OFF_EVENT_FLAGS);
  assign wrSoft   = regBus.wrEn & (regBus.addr == OFF_SOFT_EVT);
  assign wrChan   = regBus.wrEn & (regBus.addr == OFF_CHAN_CTRL_A);
  assign wrOut    = regBus.wrEn & (regBus.addr == OFF_OUT_CTRL);

  // Read multiplexer; generation bits and unmapped words read as zero.
  // Flags are read from their register, so one set in the read cycle does not show.
  always_comb begin
    case (regBus.addr)
      OFF_SLAVE_CFG:   regBus.rdata = slaveCfg_q;
      OFF_DMA_IRQ_EN:  regBus.rdata = dmaIrqEn_q;
      OFF_EVENT_FLAGS: regBus.rdata = {15'h0000, flags};
      OFF_CHAN_CTRL_A: regBus.rdata = chanCtrlA_q;
      OFF_OUT_CTRL:    regBus.rdata = outCtrl_q;
      default:         regBus.rdata = 32'h0000_0000;
    endcase
  end

  // Synchronisation bit register.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slaveCfg_q <= RST_SLAVE_CFG;
    end else if (wrSlave) begin
      slaveCfg_q <= {24'h00_0000, regBus.wdata[SYNC_START_BIT], 7'h00};
    end
  end

  // DMA and interrupt enable register.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dmaIrqEn_q <= RST_DMA_IRQ_EN;
    end else if (wrDmaIrq) begin
      dmaIrqEn_q <= regBus.wdata & MASK_DMA_IRQ_EN;
    end
  end

  // Channel control register; held whole, only as 32-bit words.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chanCtrlA_q <= RST_CHAN_CTRL_A;
    end else if (wrChan) begin
      chanCtrlA_q <= regBus.wdata & MASK_CHAN_CTRL_A;
    end
  end

  // Generation bits live one cycle and then return to zero by themselves.
  // Software therefore always reads them back as zero.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      softGen_q <= 9'h000;
    end else if (wrSoft) begin
      softGen_q <= regBus.wdata[8:0];
    end else begin
      softGen_q <= 9'h000;
    end
  end

  // Output control: shadow enable and main output enable.
  // A break of either kind, by pin or by software, drops the outputs.
  // The break wins over a write of the enable in the same cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      outCtrl_q <= RST_OUT_CTRL;
    end else begin
      if (wrOut) begin
        outCtrl_q <= {30'h0000_0000, regBus.wdata[OUT_EN_BIT],
                      regBus.wdata[SHADOW_EN_BIT]};
      end
      if (brkAAny | brkBAny | sysBreakActive) begin
        outCtrl_q[OUT_EN_BIT] <= 1'b0;
      end
    end
  end

  // Input mode of channels 0 and 1 follows their mode selection fields.
  // Any nonzero mode code means the channel captures.
  assign inMode = {chanInputModeHi,
                   chanCtrlA_q[CH1_MS_LSB +: 2] != 2'b00,
                   chanCtrlA_q[CH0_MS_LSB +: 2] != 2'b00};

  // Capture or compare from the channel, or a channel generation bit.
  assign ccAll     = ccEvt | {1'b0, softGen_q[EV_CC0 +: NUM_CC]};
  assign commutAny = commutEvt | softGen_q[EV_COMMUT];
  assign brkAAny   = breakInputA | softGen_q[EV_BRK_A];
  assign brkBAny   = breakInputB | softGen_q[EV_BRK_B];

  // Hardware set sources for every flag.
  // Held break levels set their flags again on every cycle.
  always_comb begin
    flagSet = 17'h0_0000;
    flagSet[EV_UPD]  = updEvt | softGen_q[EV_UPD];
    flagSet[EV_CC0 +: NUM_CC] = ccAll[NUM_CC-1:0];
    flagSet[FL_CC4]  = ccAll[4];
    flagSet[EV_COMMUT] = commutAny;
    flagSet[EV_TRIG] = trigEvt | softGen_q[EV_TRIG];
    flagSet[EV_BRK_A] = brkAAny;
    flagSet[EV_BRK_B] = brkBAny;
    flagSet[FL_SYS_BRK] = sysBreakActive;
    // A capture on channels 0 to 3 while the channel flag still stands is an over-capture.
    flagSet[FL_OVC0 +: NUM_CC] = ccAll[NUM_CC-1:0]
                                 & inMode[NUM_CC-1:0]
                                 & flags[EV_CC0 +: NUM_CC];
  end

  // Break flags may only be cleared while their source is inactive.
  // A clear racing a held break thus never loses the event.
  always_comb begin
    flagClrOk = 17'h1_FFFF;
    flagClrOk[EV_BRK_A]   = ~breakInputA;
    flagClrOk[EV_BRK_B]   = ~breakInputB;
    flagClrOk[FL_SYS_BRK] = ~sysBreakActive;
  end

  // Flag register.
  event_flag_bank #(
    .WIDTH (17),
    .MASK  (MASK_FLAGS[16:0])
  ) u_flags (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .hwSet      (flagSet),
    .swWrite    (wrFlags),
    .swData     (regBus.wdata[16:0]),
    .clrAllowed (flagClrOk),
    .flags_q    (flags)
  );

  // Interrupt lines: flag and enable, break sources sharing one enable.
  // Lines are levels and fall one cycle after the flag clears.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqLines <= 8'h00;
    end else begin
      irqLines[6:0] <= flags[6:0] & dmaIrqEn_q[IRQ_EN_LSB +: 7];
      irqLines[BREAK_IRQ_BIT] <= (flags[EV_BRK_A] | flags[EV_BRK_B]
                                  | flags[FL_SYS_BRK])
                                 & dmaIrqEn_q[BREAK_IRQ_BIT];
    end
  end

  // DMA request pulses: update, four channels, commutation, trigger.
  // They follow events, so a standing flag asks only once.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dmaReq <= 7'h00;
    end else begin
      dmaReq <= flagSet[6:0] & dmaIrqEn_q[DMA_EN_LSB +: 7];
    end
  end

  // Trigger input rising edge starts the counter when sync is chosen.
  // Its history resets low, the idle trigger level.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigPrev_q     <= 1'b0;
      syncStartPulse <= 1'b0;
    end else begin
      trigPrev_q     <= triggerIn;
      syncStartPulse <= slaveCfg_q[SYNC_START_BIT]
                        & triggerIn & ~trigPrev_q;
    end
  end

  // Update generation drives counter clear or reload and prescaler clear.
  // Only the generation bit acts here, not counter updates.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counterClear   <= 1'b0;
      counterReload  <= 1'b0;
      prescalerClear <= 1'b0;
    end else begin
      counterClear   <= softGen_q[EV_UPD] & ~countDown;
      counterReload  <= softGen_q[EV_UPD] & countDown;
      prescalerClear <= softGen_q[EV_UPD];
    end
  end

  // Channel generation in input mode also captures the counter value.
  // Channels in output mode only take the flag.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ccCaptureReq <= 5'h00;
    end else begin
      ccCaptureReq <= {1'b0, softGen_q[EV_CC0 +: NUM_CC]}
                      & inMode;
    end
  end

  // Main output enable follows its control bit, breaks having cleared it.
  // The break term drops it in the cycle after the event, a cycle before the cleared bit would.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mainOutEnable <= 1'b0;
    end else begin
      mainOutEnable <= outCtrl_q[OUT_EN_BIT]
                       & ~(brkAAny | brkBAny);
    end
  end

  // Active channel controls: direct without shadowing, else on commutation.
  // Without shadowing they trail the registers by one cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chanEnActive <= 10'h000;
      chan0CmpMode <= 4'h0;
      chan1CmpMode <= 4'h0;
    end else if (~outCtrl_q[SHADOW_EN_BIT] | commutAny) begin
      chanEnActive <= chanEnShadow;
      chan0CmpMode <= cmpField(chanCtrlA_q, 1'b0);
      chan1CmpMode <= cmpField(chanCtrlA_q, 1'b1);
    end
  end

endmodule

// *** rtl/timer_evt_pkg.sv ***
// Register map, field positions and reset values of the timer event slice.
package timer_evt_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_SLAVE_CFG     = 8'h08;
  localparam logic [7:0] OFF_DMA_IRQ_EN    = 8'h0C;
  localparam logic [7:0] OFF_EVENT_FLAGS   = 8'h10;
  localparam logic [7:0] OFF_SOFT_EVT      = 8'h14;
  localparam logic [7:0] OFF_CHAN_CTRL_A   = 8'h18;
  localparam logic [7:0] OFF_OUT_CTRL      = 8'h40;

  // Reset values.
  localparam logic [31:0] RST_SLAVE_CFG    = 32'h0000_0000;
  localparam logic [31:0] RST_DMA_IRQ_EN   = 32'h0000_0000;
  localparam logic [31:0] RST_EVENT_FLAGS  = 32'h0000_0000;
  localparam logic [31:0] RST_CHAN_CTRL_A  = 32'h0000_0000;
  localparam logic [31:0] RST_OUT_CTRL     = 32'h0000_0000;

  // Writable bit masks; other bits read as zero.
  localparam logic [31:0] MASK_DMA_IRQ_EN  = 32'h0000_7FFF;
  localparam logic [31:0] MASK_FLAGS       = 32'h0001_3FFF;
  localparam logic [31:0] MASK_SOFT_EVT    = 32'h0000_01FF;
  localparam logic [31:0] MASK_CHAN_CTRL_A = 32'h0101_FFFF;

  // Field positions.
  localparam int SYNC_START_BIT  = 7;
  localparam int IRQ_EN_LSB      = 0;
  localparam int DMA_EN_LSB      = 8;
  localparam int BREAK_IRQ_BIT   = 7;
  localparam int SHADOW_EN_BIT   = 0;
  localparam int OUT_EN_BIT      = 1;

  // Event and flag positions, shared by flags, generation and enables.
  localparam int EV_UPD     = 0;
  localparam int EV_CC0     = 1;
  localparam int EV_COMMUT  = 5;
  localparam int EV_TRIG    = 6;
  localparam int EV_BRK_A   = 7;
  localparam int EV_BRK_B   = 8;
  localparam int FL_OVC0    = 9;
  localparam int FL_SYS_BRK = 13;
  localparam int FL_CC4     = 16;

  // Compare control and mode selection field positions in the channel control register.
  localparam int CH0_CMP_LO = 4;
  localparam int CH0_CMP_HI = 16;
  localparam int CH1_CMP_LO = 12;
  localparam int CH1_CMP_HI = 24;
  localparam int CH0_MS_LSB = 0;
  localparam int CH1_MS_LSB = 8;

  // Bus access phases of the register slave.
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WAIT,
    PH_DONE
  } bus_phase_e;

endpackage

// *** rtl/reg_access_if.sv ***
// Carrier between the bus slave and the register core.
`timescale 1ns/1ps
interface reg_access_if;
  logic        wrEn;
  logic        rdEn;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport slave (output wrEn, output rdEn, output addr, output wdata,
                 input rdata);
  modport core  (input wrEn, input rdEn, input addr, input wdata,
                 output rdata);
endinterface

// *** rtl/ahb_reg_slave.sv ***
// AHB-Lite slave that turns single word transfers into register accesses.
`timescale 1ns/1ps
module ahb_reg_slave
  import timer_evt_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave side.
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Register side.
  reg_access_if.slave      regs
);

  bus_phase_e phase_q;
  logic       write_q;
  logic [7:0] addr_q;
  logic       take;

  // Only NONSEQ or SEQ transfers to this slave open a data phase.
  assign take = hsel & hready & htrans[1];

  // Every transfer gets one wait state so read data leaves a flip-flop.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_IDLE;
      write_q <= 1'b0;
      addr_q  <= 8'h00;
    end else begin
      case (phase_q)
        PH_IDLE: begin
          if (take) begin
            phase_q <= PH_WAIT;
            write_q <= hwrite;
            addr_q  <= haddr;
          end
        end
        PH_WAIT: phase_q <= PH_DONE;
        PH_DONE: begin
          if (take) begin
            phase_q <= PH_WAIT;
            write_q <= hwrite;
            addr_q  <= haddr;
          end else begin
            phase_q <= PH_IDLE;
          end
        end
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  // Access strobes fire in the first data phase cycle, with hwdata valid.
  // Word size is taken on trust; narrower sizes act as whole words.
  assign regs.wrEn  = (phase_q == PH_WAIT) & write_q;
  assign regs.rdEn  = (phase_q == PH_WAIT) & ~write_q;
  assign regs.addr  = addr_q;
  assign regs.wdata = hwdata;

  // Ready, read data and response come from flip-flops.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
    end else begin
      if (phase_q == PH_WAIT) begin
        hreadyout <= 1'b1;
      end else if (take) begin
        hreadyout <= 1'b0;
      end
      if (regs.rdEn) begin
        hrdata <= regs.rdata;
      end
    end
  end

  // Every answer is OKAY.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  logic unusedSize;
  assign unusedSize = ^hsize;

endmodule

// *** rtl/event_flag_bank.sv ***
// Sticky event flags, set by hardware and cleared by writing zero.
`timescale 1ns/1ps
module event_flag_bank #(
  parameter int          WIDTH = 17,
  parameter logic [16:0] MASK  = 17'h1_3FFF
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Hardware set pulses or levels.
  input  wire logic [WIDTH-1:0] hwSet,
  // Software write of the flag register and its data.
  input  wire logic             swWrite,
  input  wire logic [WIDTH-1:0] swData,
  // Per-flag permission for a software clear.
  input  wire logic [WIDTH-1:0] clrAllowed,
  output logic      [WIDTH-1:0] flags_q
);

  logic [WIDTH-1:0] clrReq;

  // A written zero clears; a written one leaves the flag alone.
  assign clrReq = swWrite ? (~swData & clrAllowed) : '0;

  // Set wins over a clear arriving in the same cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= ((flags_q & ~clrReq) | hwSet) & MASK;
    end
  end

endmodule

// *** verif/timer_evt_checker.sv ***
// Port checker for the timer event, interrupt and DMA slice.
`timescale 1ns/1ps
module timer_evt_checker
  import timer_evt_pkg::*;
(
  // Clock, reset and bus.
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // Events and results.
  input wire logic        updEvt,
  input wire logic        triggerIn,
  input wire logic        breakInputA,
  input wire logic        breakInputB,
  input wire logic        countDown,
  input wire logic [7:0]  irqLines,
  input wire logic [6:0]  dmaReq,
  input wire logic        syncStartPulse,
  input wire logic        counterClear,
  input wire logic        counterReload,
  input wire logic        prescalerClear
);
  logic [7:0]  addr_q;
  logic        wr_q;
  logic [14:0] en_q;
  logic        sync_q;

  // Remembers the address phase of a write until its data phase ends.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 8'h00;
      wr_q   <= 1'h0;
    end else if (hready) begin
      addr_q <= haddr;
      wr_q   <= hsel && htrans[1] && hwrite;
    end
  end

  // Mirrors the enables and the sync bit once a write completes.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q   <= 15'h0000;
      sync_q <= 1'h0;
    end else if (wr_q && hready) begin
      if (addr_q == OFF_DMA_IRQ_EN) en_q <= hwdata[14:0];
      if (addr_q == OFF_SLAVE_CFG) sync_q <= hwdata[SYNC_START_BIT];
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  dma_gate_a: assert property ((dmaReq & ~en_q[14:8]) == 7'h00)
    else $error("DMA request without its enable.");
  dma_upd_a: assert property (updEvt && en_q[8] |=> dmaReq[0])
    else $error("Update DMA request missing.");
  irq_gate_a: assert property ((irqLines & ~en_q[7:0]) == 8'h00)
    else $error("Interrupt line without its enable.");
  irq_upd_a: assert property (updEvt && en_q[0] |=> ##1 irqLines[0])
    else $error("Update interrupt missing.");
  brk_a_irq_a: assert property (breakInputA && en_q[7] |=> ##1 irqLines[7])
    else $error("First break interrupt missing.");
  brk_b_irq_a: assert property (breakInputB && en_q[7] |=> ##1 irqLines[7])
    else $error("Second break interrupt missing.");
  sync_start_a: assert property ($rose(triggerIn) && sync_q |=> syncStartPulse)
    else $error("Sync start pulse missing.");
  upd_gen_a: assert property (prescalerClear |->
    (counterClear != counterReload) && (counterReload == $past(countDown)))
    else $error("Update generation picked the wrong action.");

  // Main scenarios reached.
  cover property (dmaReq[6]);
  cover property (syncStartPulse);
  cover property (counterReload);
endmodule

bind timer_event_irq_dma_control timer_evt_checker u_check (.*);

// *** verif/ahb_host_model.sv ***
// Bus master model that stands for software on the register bus.
`timescale 1ns/1ps
module ahb_host_model (
  // Clock and slave answer.
  input  wire logic        core_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Request lines.
  output logic             hsel,
  output logic [7:0]       haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // Only whole-word transfers are ever issued.
  assign hsize = 3'h2;

  // The bus starts idle.
  initial begin
    hsel   = 1'h0;
    haddr  = 8'h00;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0000_0000;
  end

  // One single transfer; each phase is held until ready is sampled high.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'h1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask
endmodule

// *** verif/timer_event_irq_dma_control_tb.sv ***
// Self-checking testbench of the timer event, interrupt and DMA slice.
`timescale 1ns/1ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module timer_event_irq_dma_control_tb
  import timer_evt_pkg::*;
;
  logic        core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic        updEvt, trigEvt, commutEvt, triggerIn, countDown;
  logic        breakInputA, breakInputB, sysBreakActive;
  logic        syncStartPulse, counterClear, counterReload;
  logic        prescalerClear, mainOutEnable;
  logic [1:0]  htrans;
  logic [2:0]  hsize, chanInputModeHi, seen_q;
  logic [3:0]  chan0CmpMode, chan1CmpMode;
  logic [4:0]  ccEvt, ccCaptureReq;
  logic [6:0]  dmaReq;
  logic [7:0]  haddr, irqLines;
  logic [9:0]  chanEnShadow, chanEnActive;
  logic [31:0] hwdata, hrdata, rdv;
  wire logic   hready;
  int          errors, samples_checked, cycles;

  assign hready = hreadyout;
  timer_event_irq_dma_control DUT (.*);
  ahb_host_model host (.*);

  // Clock of 4 ns period.
  always #2 core_clk = ~core_clk;

  // Counts cycles against the ceiling and records one-cycle pulses.
  always @(posedge core_clk) begin
    cycles++;
    seen_q <= seen_q | {counterReload, counterClear, ccCaptureReq[0]};
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Bus helpers and a one-cycle event pulse.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'h1, a, d, rdv);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'h0, a, 32'h0000_0000, rdv);
    `CHK(rdv, e)
    `CHK(hresp, 1'h0)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic evt(input logic [7:0] m);
    @(posedge core_clk);
    {commutEvt, trigEvt, ccEvt, updEvt} <= m;
    @(posedge core_clk);
    {commutEvt, trigEvt, ccEvt, updEvt} <= 8'h00;
    #1;
  endtask

  // Reset values, writable mask and an unmapped place.
  task automatic t_regs();
    rdc(OFF_DMA_IRQ_EN, 32'h0000_0000);
    rdc(OFF_EVENT_FLAGS, 32'h0000_0000);
    rdc(OFF_CHAN_CTRL_A, 32'h0000_0000);
    wr(OFF_DMA_IRQ_EN, 32'hFFFF_FFFF);
    rdc(OFF_DMA_IRQ_EN, 32'h0000_7FFF);
    wr(OFF_DMA_IRQ_EN, 32'h0000_0000);
    wr(8'h30, 32'hFFFF_FFFF);
    rdc(8'h30, 32'h0000_0000);
  endtask

  // Update events with enables off, flag clearing, then enabled requests.
  task automatic t_upd();
    evt(8'h01);
    `CHK(dmaReq, 7'h00)
    tick(1);
    `CHK(irqLines, 8'h00)
    rdc(OFF_EVENT_FLAGS, 32'h0000_0001);
    wr(OFF_EVENT_FLAGS, 32'hFFFF_FFFF);
    rdc(OFF_EVENT_FLAGS, 32'h0000_0001);
    wr(OFF_EVENT_FLAGS, 32'hFFFF_FFFE);
    rdc(OFF_EVENT_FLAGS, 32'h0000_0000);
    wr(OFF_DMA_IRQ_EN, 32'h0000_4101);
    evt(8'h41);
    `CHK(dmaReq, 7'h41)
    tick(1);
    `CHK(irqLines, 8'h01)
    wr(OFF_EVENT_FLAGS, 32'h0000_0000);
    tick(1);
    `CHK(irqLines, 8'h00)
  endtask

  // Captures on an input channel, compares on an output one, channel 4.
  task automatic t_cc();
    wr(OFF_CHAN_CTRL_A, 32'h0000_0001);
    evt(8'h02);
    evt(8'h02);
    evt(8'h04);
    evt(8'h04);
    evt(8'h20);
    rdc(OFF_EVENT_FLAGS, 32'h0001_0206);
    wr(OFF_EVENT_FLAGS, 32'h0000_0000);
    rdc(OFF_EVENT_FLAGS, 32'h0000_0000);
  endtask

  // Each break source held: clear refused, then accepted once released.
  task automatic t_brk();
    int bp[3] = '{7, 8, 13};
    wr(OFF_DMA_IRQ_EN, 32'h0000_0080);
    for (int i = 0; i < 3; i++) begin
      {sysBreakActive, breakInputB, breakInputA} <= 3'h1 << i;
      tick(2);
      `CHK(irqLines, 8'h80)
      wr(OFF_EVENT_FLAGS, 32'h0000_0000);
      rdc(OFF_EVENT_FLAGS, 32'h1 << bp[i]);
      {sysBreakActive, breakInputB, breakInputA} <= 3'h0;
      wr(OFF_EVENT_FLAGS, 32'h0000_0000);
      rdc(OFF_EVENT_FLAGS, 32'h0000_0000);
    end
  endtask

  // Software generation of update, channel 0, commutation, trigger and both breaks, watching the output enable.
  task automatic t_gen();
    int gb[6] = '{0, 1, 5, 6, 7, 8};
    countDown <= 1'h0;
    for (int i = 0; i < 6; i++) begin
      wr(OFF_OUT_CTRL, 32'h0000_0002);
      wr(OFF_SOFT_EVT, 32'h1 << gb[i]);
      rdc(OFF_EVENT_FLAGS, 32'h1 << gb[i]);
      `CHK(mainOutEnable, gb[i] < 7)
      wr(OFF_EVENT_FLAGS, 32'h0000_0000);
    end
    countDown <= 1'h1;
    wr(OFF_SOFT_EVT, 32'h0000_0001);
    rdc(OFF_SOFT_EVT, 32'h0000_0000);
    `CHK(seen_q, 3'h7)
  endtask

  // Trigger edges with the sync start bit set, then cleared.
  task automatic t_sync();
    for (int s = 1; s >= 0; s--) begin
      wr(OFF_SLAVE_CFG, (s == 1) ? 32'h0000_0080 : 32'h0000_0000);
      triggerIn <= 1'h1;
      tick(1);
      `CHK(syncStartPulse, s == 1)
      @(posedge core_clk);
      triggerIn <= 1'h0;
      #1;
      `CHK(syncStartPulse, 1'h0)
    end
  endtask

  // Compare fields and channel enables, direct and through shadows.
  task automatic t_cmp();
    chanEnShadow <= 10'h2A5;
    wr(OFF_CHAN_CTRL_A, 32'h0101_7060);
    tick(2);
    `CHK({chan1CmpMode, chan0CmpMode}, 8'hFE)
    `CHK(chanEnActive, 10'h2A5)
    rdc(OFF_CHAN_CTRL_A, 32'h0101_7060);
    wr(OFF_OUT_CTRL, 32'h0000_0001);
    chanEnShadow <= 10'h15A;
    tick(3);
    `CHK(chanEnActive, 10'h2A5)
    evt(8'h80);
    tick(1);
    `CHK(chanEnActive, 10'h15A)
    @(posedge core_clk);
    chanEnShadow <= 10'h3FF;
    wr(OFF_SOFT_EVT, 32'h0000_0020);
    tick(2);
    `CHK(chanEnActive, 10'h3FF)
    rdc(OFF_EVENT_FLAGS, 32'h0000_0021);
  endtask

  // Drives every input at time zero, releases reset, runs the scenarios.
  initial begin
    core_clk = 1'h0;
    rst_n = 1'h0;
    {commutEvt, trigEvt, ccEvt, updEvt} = 8'h00;
    {sysBreakActive, breakInputB, breakInputA} = 3'h0;
    {triggerIn, countDown, chanInputModeHi} = 5'h00;
    chanEnShadow = 10'h000;
    seen_q = 3'h0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'h1;
    t_regs();
    t_upd();
    t_cc();
    t_brk();
    t_gen();
    t_sync();
    t_cmp();
    results();
  end
endmodule
